// File: uart_ctrl_defines.vh
// register offsets, field positions, reset values and timing counts for uart_ctrl
// assumes a 40 MHz aclk and a 32-bit axi4-lite register bus
`ifndef UART_CTRL_DEFINES_VH
`define UART_CTRL_DEFINES_VH
`define ADDR_W          8
`define OFF_DATA        8'h00
`define OFF_FMT_STATE   8'h04
`define OFF_MODEM_CTRL  8'h08
`define OFF_RATE_MSTAT  8'h0c
`define MC_TERM_READY   0
`define MC_SEND_REQ     1
`define MC_IRQ_MASTER   2
`define MC_LINE_IRQ     3
`define MC_MODE_LO      4
`define MC_MODE_HI      5
`define MC_RX_EN        6
`define MODE_NORMAL     2'h0
`define MODE_BREAK      2'h1
`define MODE_ECHO       2'h2
`define MODE_LOOP       2'h3
`define US_PAR_ERR      0
`define US_FRM_ERR      1
`define US_OVR_ERR      2
`define US_RX_BREAK     3
`define US_LINE_CHG     4
`define US_TX_DONE      5
`define US_TX_EMPTY     6
`define US_RX_AVAIL     7
`define RS_CLK_SEL      7
`define FF_TWO_STOP     0
`define MODEM_CTRL_RST  8'h00
`define HALF_BIT_TICKS  4'h7
`define BIT_TICKS_LAST  4'hf
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// File: uart_ctrl.v
// serial controller: modem lines, clock-out select, tx/rx holding flags,
// interrupt gating, chip-select gating, reset behaviour, axi4-lite registers.
// assumes pins arrive asynchronously to aclk; osc_input_pin is slow vs aclk.
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "uart_ctrl_defines.vh"
module uart_ctrl (
   input  wire                aclk,
   input  wire                aresetn,
   input  wire [`ADDR_W-1:0]  s_axi_awaddr,
   input  wire                s_axi_awvalid,
   output reg                 s_axi_awready,
   input  wire [31:0]         s_axi_wdata,
   input  wire [3:0]          s_axi_wstrb,
   input  wire                s_axi_wvalid,
   output reg                 s_axi_wready,
   output reg  [1:0]          s_axi_bresp,
   output reg                 s_axi_bvalid,
   input  wire                s_axi_bready,
   input  wire [`ADDR_W-1:0]  s_axi_araddr,
   input  wire                s_axi_arvalid,
   output reg                 s_axi_arready,
   output reg  [31:0]         s_axi_rdata,
   output reg  [1:0]          s_axi_rresp,
   output reg                 s_axi_rvalid,
   input  wire                s_axi_rready,
   input  wire                chip_select_n,
   input  wire                osc_input_pin,
   input  wire                serial_in_pin,
   input  wire                clear_to_send_n,
   input  wire                peer_ready_input_n,
   output reg                 serial_out_pin,
   output reg                 terminal_ready_output_n,
   output reg                 send_request_output_n,
   output reg                 clock_out_pin,
   output reg                 tx_holding_empty,
   output reg                 rx_char_available,
   output reg                 interrupt_request_pin
);
   localparam [3:0] S_IDLE = 4'h1, S_START = 4'h2, S_DATA = 4'h4, S_STOP = 4'h8;
   // two-flop synchronisers; stage one feeds stage two only
   reg  [4:0] sync1_r, sync2_r;
   reg        osc_prev_r, cts_prev_r, prdy_prev_r;
   wire       cs_ok   = ~sync2_r[0];
   wire       osc_s   = sync2_r[1];
   wire       sin_s   = sync2_r[2];
   wire       cts_s_n = sync2_r[3];
   wire       prdy_s_n = sync2_r[4];
   // synchronisers keep sampling through reset, so the pins are already settled at release
   always @(posedge aclk) begin
      sync1_r <= {peer_ready_input_n, clear_to_send_n, serial_in_pin, osc_input_pin,
                  chip_select_n};
      sync2_r <= sync1_r;
   end
   // registers
   reg  [7:0] modem_ctrl_reg, rate_select_reg, frame_format_reg, tx_holding_reg, rx_holding_reg;
   reg        par_err_r, frm_err_r, ovr_err_r, rx_brk_r, line_chg_r;
   wire [1:0] mode    = modem_ctrl_reg[`MC_MODE_HI:`MC_MODE_LO];
   wire       loop_m  = (mode == `MODE_LOOP);
   // axi write path: address and data taken in either order
   reg  [`ADDR_W-1:0] aw_addr_r;
   reg  [7:0]         w_data_r;
   reg                aw_have_r, w_have_r, w_lane_r;
   wire               wr_go  = aw_have_r & w_have_r & ~s_axi_bvalid;
   wire               wr_ok  = wr_go & w_lane_r & cs_ok;
   wire               wr_tx  = wr_ok & (aw_addr_r == `OFF_DATA);
   wire               wr_ff  = wr_ok & (aw_addr_r == `OFF_FMT_STATE);
   wire               wr_mc  = wr_ok & (aw_addr_r == `OFF_MODEM_CTRL);
   wire               wr_rs  = wr_ok & (aw_addr_r == `OFF_RATE_MSTAT);
   wire               wr_map = (aw_addr_r[`ADDR_W-1:4] == 4'h0) & (aw_addr_r[1:0] == 2'h0);
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r     <= 1'b0;
         w_have_r      <= 1'b0;
         aw_addr_r     <= {`ADDR_W{1'b0}};
         w_data_r      <= 8'h00;
         w_lane_r      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
      end else begin
         s_axi_awready <= ~aw_have_r & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready  <= ~w_have_r & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata[7:0];
            w_lane_r <= s_axi_wstrb[0];
         end
         if (wr_go) begin
            aw_have_r    <= 1'b0;
            w_have_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   // axi read path: one-cycle answer after address taken
   wire       rd_go  = s_axi_arvalid & s_axi_arready;
   wire       rd_ok  = rd_go & cs_ok;
   wire       rd_rx  = rd_ok & (s_axi_araddr == `OFF_DATA);
   wire       rd_ms  = rd_ok & (s_axi_araddr == `OFF_RATE_MSTAT);
   wire       rd_map = (s_axi_araddr[`ADDR_W-1:4] == 4'h0) & (s_axi_araddr[1:0] == 2'h0);
   reg  [7:0] rd_val;
   // transmitter and receiver state, declared here for the status read
   reg  [3:0] tx_st_r, rx_st_r;
   always @* begin
      case (s_axi_araddr)
         `OFF_DATA:       rd_val = rx_holding_reg;
         `OFF_FMT_STATE:  rd_val = {rx_char_available, tx_holding_empty,
                                    tx_holding_empty & tx_st_r[0], line_chg_r,
                                    rx_brk_r, ovr_err_r, frm_err_r, par_err_r};
         `OFF_MODEM_CTRL: rd_val = modem_ctrl_reg;
         `OFF_RATE_MSTAT: rd_val = {6'h00, ~prdy_s_n, ~cts_s_n};
         default:         rd_val = 8'h00;
      endcase
   end
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, cs_ok ? rd_val : 8'h00};
            s_axi_rresp  <= rd_map ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
   // frame format survives reset; only its stop-bit count is used here
   always @(posedge aclk) begin
      if (wr_ff)
         frame_format_reg <= w_data_r;
   end
   // rate select keeps its divider fields through reset, clock-out select clears
   always @(posedge aclk) begin
      if (!aresetn)
         rate_select_reg[`RS_CLK_SEL] <= 1'b0;
      else if (wr_rs)
         rate_select_reg <= w_data_r;
   end
   always @(posedge aclk) begin
      if (!aresetn)
         modem_ctrl_reg <= `MODEM_CTRL_RST;
      else if (wr_mc)
         modem_ctrl_reg <= w_data_r;
   end
   // rate generator: prescaler (bits 6:5) then divisor (bits 4:0 + 1) in half periods
   // of the 16x clock, so the 16x output keeps a 50% duty cycle
   reg  [2:0] pre_cnt_r;
   reg  [4:0] div_cnt_r;
   reg        clk16_r;
   reg  [2:0] pre_last;
   always @* begin
      case (rate_select_reg[6:5])
         2'h0:    pre_last = 3'h0;
         2'h1:    pre_last = 3'h2;
         2'h2:    pre_last = 3'h3;
         default: pre_last = 3'h4;
      endcase
   end
   wire osc_rise = osc_s & ~osc_prev_r;
   wire pre_tick = osc_rise & (pre_cnt_r == pre_last);
   wire half_tk  = pre_tick & (div_cnt_r == rate_select_reg[4:0]);
   wire tick16   = half_tk & ~clk16_r;
   always @(posedge aclk) begin
      if (!aresetn) begin
         pre_cnt_r  <= 3'h0;
         div_cnt_r  <= 5'h00;
         clk16_r    <= 1'b0;
         osc_prev_r <= 1'b0;
      end else begin
         osc_prev_r <= osc_s;
         if (osc_rise)
            pre_cnt_r <= pre_tick ? 3'h0 : pre_cnt_r + 3'h1;
         if (pre_tick)
            div_cnt_r <= half_tk ? 5'h00 : div_cnt_r + 5'h01;
         if (half_tk)
            clk16_r <= ~clk16_r;
      end
   end
   // transmitter
   reg  [3:0] tx_sub_r, rx_sub_r;
   reg  [2:0] tx_bit_r, rx_bit_r;
   reg  [7:0] tx_sh_r, rx_sh_r;
   reg        tx_line_r, tx_stop2_r;
   wire       tx_load = tx_st_r[0] & ~tx_holding_empty & ~cts_s_n & (mode != `MODE_ECHO);
   wire       tx_bend = tick16 & (tx_sub_r == `BIT_TICKS_LAST);
   always @(posedge aclk) begin
      if (!aresetn) begin
         tx_st_r          <= S_IDLE;
         tx_sub_r         <= 4'h0;
         tx_bit_r         <= 3'h0;
         tx_sh_r          <= 8'h00;
         tx_line_r        <= 1'b1;
         tx_stop2_r       <= 1'b0;
         tx_holding_empty <= 1'b1;
      end else begin
         if (tick16)
            tx_sub_r <= tx_sub_r + 4'h1;
         // a host write in the handoff cycle refills, so empty stays low
         if (wr_tx) begin
            tx_holding_reg   <= w_data_r;
            tx_holding_empty <= 1'b0;
         end else if (tx_load) begin
            tx_holding_empty <= 1'b1;
         end
         case (tx_st_r)
            S_IDLE: begin
               tx_line_r <= 1'b1;
               if (tx_load) begin
                  tx_sh_r    <= tx_holding_reg;
                  tx_stop2_r <= frame_format_reg[`FF_TWO_STOP];
                  tx_sub_r   <= 4'h0;
                  tx_line_r  <= 1'b0;
                  tx_st_r    <= S_START;
               end
            end
            S_START: if (tx_bend) begin
               tx_line_r <= tx_sh_r[0];
               tx_bit_r  <= 3'h0;
               tx_st_r   <= S_DATA;
            end
            S_DATA: if (tx_bend) begin
               tx_sh_r  <= {1'b1, tx_sh_r[7:1]};
               tx_bit_r <= tx_bit_r + 3'h1;
               if (tx_bit_r == 3'h7) begin
                  tx_line_r <= 1'b1;
                  tx_st_r   <= S_STOP;
               end else begin
                  tx_line_r <= tx_sh_r[1];
               end
            end
            S_STOP: if (tx_bend) begin
               if (tx_stop2_r)
                  tx_stop2_r <= 1'b0;
               else
                  tx_st_r <= S_IDLE;
            end
            default: tx_st_r <= S_IDLE;
         endcase
      end
   end
   // receiver: loop mode feeds it from the transmitter, never from the pin
   wire rx_in   = loop_m ? tx_line_r : sin_s;
   wire rx_en   = modem_ctrl_reg[`MC_RX_EN];
   wire rx_mid  = tick16 & (rx_sub_r == `BIT_TICKS_LAST);
   always @(posedge aclk) begin
      if (!aresetn) begin
         rx_st_r           <= S_IDLE;
         rx_sub_r          <= 4'h0;
         rx_bit_r          <= 3'h0;
         rx_sh_r           <= 8'h00;
         rx_holding_reg    <= 8'h00;
         rx_char_available <= 1'b0;
         par_err_r         <= 1'b0;
         frm_err_r         <= 1'b0;
         ovr_err_r         <= 1'b0;
         rx_brk_r          <= 1'b0;
      end else begin
         if (tick16)
            rx_sub_r <= rx_sub_r + 4'h1;
         if (rd_rx)
            rx_char_available <= 1'b0;
         case (rx_st_r)
            S_IDLE: if (rx_en & ~rx_in) begin
               rx_sub_r <= `HALF_BIT_TICKS;
               rx_st_r  <= S_START;
            end
            S_START: if (rx_mid) begin
               rx_bit_r <= 3'h0;
               rx_st_r  <= rx_in ? S_IDLE : S_DATA;
            end
            S_DATA: if (rx_mid) begin
               rx_sh_r  <= {rx_in, rx_sh_r[7:1]};
               rx_bit_r <= rx_bit_r + 3'h1;
               if (rx_bit_r == 3'h7)
                  rx_st_r <= S_STOP;
            end
            S_STOP: if (rx_mid) begin
               // a new character wins over a read in the same cycle
               rx_holding_reg    <= rx_sh_r;
               rx_char_available <= 1'b1;
               ovr_err_r         <= rx_char_available & ~rd_rx;
               frm_err_r         <= ~rx_in;
               rx_brk_r          <= ~rx_in & (rx_sh_r == 8'h00);
               rx_st_r           <= S_IDLE;
            end
            default: rx_st_r <= S_IDLE;
         endcase
      end
   end
   // modem line changes; the event beats a clearing read
   wire line_evt = (cts_s_n != cts_prev_r) | (prdy_s_n != prdy_prev_r);
   // edge history runs through reset: a line already active at release is no change
   always @(posedge aclk) begin
      cts_prev_r  <= cts_s_n;
      prdy_prev_r <= prdy_s_n;
      if (!aresetn) begin
         line_chg_r  <= 1'b0;
      end else begin
         if (line_evt)
            line_chg_r <= 1'b1;
         else if (rd_ms)
            line_chg_r <= 1'b0;
      end
   end
   // pins, all registered
   always @(posedge aclk) begin
      if (!aresetn) begin
         serial_out_pin          <= 1'b1;
         terminal_ready_output_n <= 1'b1;
         send_request_output_n   <= 1'b1;
         clock_out_pin           <= 1'b0;
         interrupt_request_pin   <= 1'b0;
      end else begin
         terminal_ready_output_n <= ~modem_ctrl_reg[`MC_TERM_READY];
         send_request_output_n   <= ~modem_ctrl_reg[`MC_SEND_REQ];
         clock_out_pin <= rate_select_reg[`RS_CLK_SEL] ? clk16_r : osc_s;
         case (mode)
            `MODE_LOOP:  serial_out_pin <= 1'b1;
            `MODE_ECHO:  serial_out_pin <= sin_s;
            `MODE_BREAK: serial_out_pin <= tx_st_r[0];
            default:     serial_out_pin <= tx_line_r;
         endcase
         interrupt_request_pin <= modem_ctrl_reg[`MC_IRQ_MASTER] &
                                  ((modem_ctrl_reg[`MC_LINE_IRQ] & line_chg_r) |
                                   rx_char_available);
      end
   end
endmodule

// File: uart_ctrl_assertions.sv
// port-level checks for uart_ctrl
// assumes one aclk domain and a synchronous, active-low aresetn
`timescale 1ns/1ps
`include "uart_ctrl_defines.vh"
module uart_ctrl_checker (
   input logic                aclk,
   input logic                aresetn,
   input logic                s_axi_bvalid,
   input logic                s_axi_arvalid,
   input logic                s_axi_arready,
   input logic [`ADDR_W-1:0]  s_axi_araddr,
   input logic                s_axi_rvalid,
   input logic [31:0]         s_axi_rdata,
   input logic [1:0]          s_axi_rresp,
   input logic                chip_select_n,
   input logic                serial_out_pin,
   input logic                terminal_ready_output_n,
   input logic                send_request_output_n,
   input logic                tx_holding_empty,
   input logic                rx_char_available,
   input logic                interrupt_request_pin
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_rst_modem;
      $rose(aresetn) |-> terminal_ready_output_n && send_request_output_n;
   endproperty
   a_rst_modem: assert property (p_rst_modem)
      else $error("modem outputs active after reset");
   property p_rst_flags;
      $rose(aresetn) |-> tx_holding_empty && !rx_char_available && !interrupt_request_pin;
   endproperty
   a_rst_flags: assert property (p_rst_flags)
      else $error("status pins wrong after reset");
   property p_rst_idle;
      $rose(aresetn) |-> serial_out_pin [*4];
   endproperty
   a_rst_idle: assert property (p_rst_idle)
      else $error("serial output left mark after reset");
   // the flag falls on the same edge that the write response rises
   property p_tx_fill;
      $fell(tx_holding_empty) |-> s_axi_bvalid || $past(s_axi_bvalid);
   endproperty
   a_tx_fill: assert property (p_tx_fill)
      else $error("holding empty fell without a write");
   property p_rx_clear;
      $fell(rx_char_available) |-> s_axi_rvalid || $past(s_axi_rvalid) || $past(s_axi_arready);
   endproperty
   a_rx_clear: assert property (p_rx_clear)
      else $error("rx available fell without a read");
   property p_cs_read;
      chip_select_n [*4] ##0 (s_axi_arvalid && s_axi_arready) |=> s_axi_rdata == 32'h0;
   endproperty
   a_cs_read: assert property (p_cs_read)
      else $error("deselected read returned data");
   property p_rd_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer)
      else $error("read answer late");
   property p_rd_slverr;
      s_axi_arvalid && s_axi_arready && (s_axi_araddr > 8'h0c || s_axi_araddr[1:0] != 2'h0)
         |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_rd_slverr: assert property (p_rd_slverr)
      else $error("unmapped read not refused");
   property p_rd_upper;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
   endproperty
   a_rd_upper: assert property (p_rd_upper)
      else $error("read data upper bits set");
endmodule
bind uart_ctrl uart_ctrl_checker chk_u (.*);

// File: line_partner.sv
// far side of the serial line: oscillator, frame sender, modem inputs
// assumes the dut 16x clock is two oscillator periods (code 0, prescale 1)
`timescale 1ns/1ps
module line_partner #(
   parameter BIT_NS = 3200
) (
   output logic osc_input_pin,
   output logic serial_in_pin,
   output logic clear_to_send_n,
   output logic peer_ready_input_n
);
   initial begin
      osc_input_pin = 1'b0;
      serial_in_pin = 1'b1;
      clear_to_send_n = 1'b0;
      peer_ready_input_n = 1'b1;
   end
   always #50 osc_input_pin = ~osc_input_pin;
   // start bit, eight data bits lsb first, then the line rests at mark
   task send_byte(input logic [7:0] b);
      integer i;
      begin
         serial_in_pin = 1'b0;
         #BIT_NS;
         for (i = 0; i < 8; i = i + 1) begin
            serial_in_pin = b[i];
            #BIT_NS;
         end
         serial_in_pin = 1'b1;
         #(2 * BIT_NS);
      end
   endtask
endmodule

// File: tb_top.sv
// register-level tests of uart_ctrl over axi4-lite
// assumes line_partner drives the serial and modem inputs
`timescale 1ns/1ps
`include "uart_ctrl_defines.vh"
module tb_top;
   logic aclk = 1'b0, aresetn = 1'b0, chip_select_n = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h1;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire osc_input_pin, serial_in_pin, clear_to_send_n, peer_ready_input_n;
   wire serial_out_pin, terminal_ready_output_n, send_request_output_n, clock_out_pin;
   wire tx_holding_empty, rx_char_available, interrupt_request_pin;
   wire [5:0] pins = {serial_out_pin, terminal_ready_output_n, send_request_output_n,
                      tx_holding_empty, rx_char_available, interrupt_request_pin};
   integer miscompares = 0, check_count = 0, n;
   uart_ctrl dut_u (.*);
   line_partner partner_u (.*);
   always #12.5 aclk = ~aclk;
   task final_report;
      begin
         if (miscompares == 0 && check_count > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("mismatch %s expected %h seen %h", name, exp, got);
         end
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      begin
         @(posedge aclk);
         s_axi_awaddr <= a;
         s_axi_wdata <= {24'h0, d};
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         n = 0;
         do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n = n + 1;
         end while (s_axi_bvalid !== 1'b1 && n < 50);
         s_axi_bready <= 1'b0;
         chk("bresp", {1'b1, er}, {s_axi_bvalid, s_axi_bresp});
      end
   endtask
   task rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
      begin
         @(posedge aclk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         n = 0;
         do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n = n + 1;
         end while (s_axi_rvalid !== 1'b1 && n < 50);
         s_axi_rready <= 1'b0;
         chk("rresp", {1'b1, er}, {s_axi_rvalid, s_axi_rresp});
         chk("rdata", {24'h0, ed}, s_axi_rdata);
      end
   endtask
   // skip one edge so a partial period after a switch is not measured
   task per(input integer exp);
      realtime t0;
      begin
         repeat (2) @(posedge clock_out_pin);
         t0 = $realtime;
         @(posedge clock_out_pin);
         chk("clock_out period", exp, $realtime - t0);
      end
   endtask
   task settle(input integer c);
      repeat (c) @(posedge aclk);
   endtask
   initial begin
      #2000000;
      miscompares = miscompares + 1;
      final_report;
   end
   initial begin
      settle(6);
      aresetn <= 1'b1;
      settle(3);
      chk("pins", 6'h3c, pins);
      rd(`OFF_MODEM_CTRL, 8'h00, `RESP_OKAY);
      rd(`OFF_FMT_STATE, 8'h60, `RESP_OKAY);
      wr(`OFF_RATE_MSTAT, 8'h00, `RESP_OKAY);
      wr(`OFF_FMT_STATE, 8'h00, `RESP_OKAY);
      wr(`OFF_MODEM_CTRL, 8'h43, `RESP_OKAY);
      settle(3);
      chk("pins", 6'h24, pins);
      rd(`OFF_MODEM_CTRL, 8'h43, `RESP_OKAY);
      wr(`OFF_MODEM_CTRL, 8'h41, `RESP_OKAY);
      settle(3);
      chk("pins", 6'h2c, pins);
      chip_select_n <= 1'b1;
      settle(4);
      wr(`OFF_MODEM_CTRL, 8'h00, `RESP_OKAY);
      rd(`OFF_MODEM_CTRL, 8'h00, `RESP_OKAY);
      chip_select_n <= 1'b0;
      settle(4);
      rd(`OFF_MODEM_CTRL, 8'h41, `RESP_OKAY);
      rd(8'h10, 8'h00, `RESP_SLVERR);
      wr(8'h06, 8'h00, `RESP_SLVERR);
      wr(`OFF_MODEM_CTRL, 8'h4d, `RESP_OKAY);
      rd(`OFF_RATE_MSTAT, 8'h01, `RESP_OKAY);
      settle(3);
      chk("irq", 1'b0, interrupt_request_pin);
      partner_u.peer_ready_input_n <= 1'b0;
      settle(6);
      chk("irq", 1'b1, interrupt_request_pin);
      rd(`OFF_FMT_STATE, 8'h70, `RESP_OKAY);
      rd(`OFF_RATE_MSTAT, 8'h03, `RESP_OKAY);
      settle(3);
      chk("irq", 1'b0, interrupt_request_pin);
      wr(`OFF_MODEM_CTRL, 8'h49, `RESP_OKAY);
      partner_u.peer_ready_input_n <= 1'b1;
      settle(6);
      chk("irq", 1'b0, interrupt_request_pin);
      wr(`OFF_MODEM_CTRL, 8'h45, `RESP_OKAY);
      settle(3);
      chk("irq", 1'b0, interrupt_request_pin);
      wr(`OFF_MODEM_CTRL, 8'h4d, `RESP_OKAY);
      settle(3);
      chk("irq", 1'b1, interrupt_request_pin);
      rd(`OFF_RATE_MSTAT, 8'h01, `RESP_OKAY);
      per(100);
      wr(`OFF_RATE_MSTAT, 8'h80, `RESP_OKAY);
      per(200);
      aresetn <= 1'b0;
      settle(6);
      aresetn <= 1'b1;
      settle(3);
      chk("pins", 6'h3c, pins);
      per(100);
      // rate code and frame format are not rewritten after this reset
      wr(`OFF_MODEM_CTRL, 8'h40, `RESP_OKAY);
      partner_u.send_byte(8'ha5);
      n = 0;
      while (rx_char_available !== 1'b1 && n < 500) begin
         @(posedge aclk);
         n = n + 1;
      end
      chk("rx_avail", 1'b1, rx_char_available);
      rd(`OFF_DATA, 8'ha5, `RESP_OKAY);
      settle(2);
      chk("rx_avail", 1'b0, rx_char_available);
      wr(`OFF_MODEM_CTRL, 8'h70, `RESP_OKAY);
      partner_u.send_byte(8'h3c);
      settle(200);
      chk("rx_avail", 1'b0, rx_char_available);
      wr(`OFF_MODEM_CTRL, 8'h40, `RESP_OKAY);
      wr(`OFF_DATA, 8'h96, `RESP_OKAY);
      wr(`OFF_DATA, 8'h69, `RESP_OKAY);
      settle(2);
      chk("tx_empty", 1'b0, tx_holding_empty);
      chk("serial_out", 1'b0, serial_out_pin);
      n = 0;
      while (tx_holding_empty !== 1'b1 && n < 3000) begin
         @(posedge aclk);
         n = n + 1;
      end
      chk("tx_empty", 1'b1, tx_holding_empty);
      final_report;
   end
endmodule
